// ===== tsic_pkg.sv
// Constants shared by the twelve-source interrupt controller
package tsic_pkg;

    // Machine cycle of four clocks; phases counted 0..3
    localparam int MC_CLKS = 4;
    localparam logic [1:0] PH_C3 = 2'h2;
    localparam logic [1:0] PH_C4 = 2'h3;
    localparam logic [2:0] CALL_MCS = 3'h4;

    // Flag vector positions
    localparam int F_EXT0 = 0;
    localparam int F_EXT1 = 1;
    localparam int F_EXT2 = 2;
    localparam int F_EXT5 = 5;
    localparam int F_OVF0 = 6;
    localparam int F_OVF1 = 7;
    localparam int F_RLD_OVF = 8;
    localparam int F_RLD_EXT = 9;
    localparam int F_WDOG = 10;
    localparam int F_RI0 = 11;
    localparam int F_TI0 = 12;
    localparam int F_RI1 = 13;
    localparam int F_TI1 = 14;
    localparam int NFLAGS = 15;
    localparam logic [NFLAGS-1:0] FLAGS_RST = 15'h0000;

    // Source numbers in fixed tie-break order, 0 highest
    localparam int NSRC = 12;
    localparam logic [3:0] S_EXT0 = 4'h0;
    localparam logic [3:0] S_OVF0 = 4'h1;
    localparam logic [3:0] S_EXT1 = 4'h2;
    localparam logic [3:0] S_OVF1 = 4'h3;
    localparam logic [3:0] S_EXT2 = 4'h7;
    localparam logic [3:0] S_EXT5 = 4'hA;

    localparam logic [15:0] VEC [NSRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063
    };

    // In-service tiers
    localparam int T_LOW = 0;
    localparam int T_HIGH = 1;
    localparam int T_PF = 2;
    localparam logic [2:0] INS_RST = 3'h0;

endpackage : tsic_pkg

// ===== tsic_ext_if.sv
// Carrier between the controller and its external pin sampler
`timescale 1ns/1ps
interface tsic_ext_if;
    logic c3_en;
    logic [5:0] fall;
    logic [5:0] low;
    modport sampler (input c3_en, output fall, output low);
    modport ctrl (output c3_en, input fall, input low);
endinterface : tsic_ext_if

// ===== tsic_ext_sampler.sv
// Synchroniser and once-per-machine-cycle sampler for the external request pins
`timescale 1ns/1ps
module tsic_ext_sampler import tsic_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [5:0] i_pins_n,
    tsic_ext_if.sampler bus
);
    logic [5:0] meta_ff;
    logic [5:0] sync_ff;
    logic [5:0] samp_ff;
    logic [5:0] fall_ff;

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_ff <= 6'h3F;
            sync_ff <= 6'h3F;
        end else begin
            meta_ff <= i_pins_n;
            sync_ff <= meta_ff;
        end
    end

    // High in one sample, low in the next gives a one-clock fall pulse
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            samp_ff <= 6'h3F;
            fall_ff <= 6'h00;
        end else if (bus.c3_en) begin
            samp_ff <= sync_ff;
            fall_ff <= samp_ff & ~sync_ff;
        end else begin
            fall_ff <= 6'h00;
        end
    end

    assign bus.fall = fall_ff;
    assign bus.low = ~samp_ff;

endmodule : tsic_ext_sampler

// ===== tsic_ctrl.sv
// Twelve-source interrupt controller: flags, gating, priority and hardware call
//
// Behaviour
// - Twelve sources, each with flag, enable, priority bit, vector; one global enable.
// - External inputs zero and one select edge or level trigger each.
// - Edge mode samples once per machine cycle; high then low sets flag.
// - Edge-mode flags zero and one clear on vectoring to their routine.
// - Level-mode flags are not cleared on vectoring; still low re-requests.
// - Inputs two to five edge only; software clears unless hardware-clear bit set.
// - Timer zero and one overflow flags set by overflow, cleared on vectoring.
// - Reload timer requests on overflow OR external flag; neither cleared by hardware.
// - Watchdog timeout sets its flag; its enable gates it; software clears.
// - Each serial port requests on receive OR transmit done; never auto-cleared.
// - Software can set or clear every flag except level-mode zero and one, raising genuine requests.
// - Individual enables gate each source; global enable blocks all but power-fail.
// - Power-fail, high, low tiers; lower tier never pre-empts one in service.
// - Same-tier ties resolved in fixed source order, external zero first.
// - Flags sampled in one machine cycle, polled and resolved in the next.
// - Call only if no equal/higher in service, last cycle, no blocking instruction.
// - Requests are not latched; every poll is evaluated afresh.
// - Call pushes program counter, not status word, then loads the vector.
// - Vectors 0003h to 0063h per source as in the vector table.
// - Only return-from-interrupt clears in-service; plain return leaves it.
// - Reset clears flags, in-service tiers and call state; enables are inputs, not reset here.
// - External inputs sampled at the third phase of every machine cycle.
// - Hardware call sequence lasts four machine cycles.
`timescale 1ns/1ps
module tsic_ctrl import tsic_pkg::*; #(
    parameter logic [15:0] PF_VECTOR = 16'h0070
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_ext_req_zero_n,
    input wire logic i_ext_req_one_n,
    input wire logic i_ext_req_two_n,
    input wire logic i_ext_req_three_n,
    input wire logic i_ext_req_four_n,
    input wire logic i_ext_req_five_n,
    input wire logic i_trig_type_zero,
    input wire logic i_trig_type_one,
    input wire logic [3:0] i_hw_clear_select,
    input wire logic i_timer_zero_ovf,
    input wire logic i_timer_one_ovf,
    input wire logic i_reload_timer_ovf,
    input wire logic i_reload_timer_ext,
    input wire logic i_watchdog_timeout,
    input wire logic i_serial0_rx_done,
    input wire logic i_serial0_tx_done,
    input wire logic i_serial1_rx_done,
    input wire logic i_serial1_tx_done,
    input wire logic i_flag_wr,
    input wire logic [NFLAGS-1:0] i_flag_wr_sel,
    input wire logic [NFLAGS-1:0] i_flag_wr_val,
    input wire logic [NSRC-1:0] i_src_enable,
    input wire logic [NSRC-1:0] i_src_priority,
    input wire logic i_global_enable,
    input wire logic i_power_fail_request,
    input wire logic i_pf_enable,
    input wire logic i_last_cycle,
    input wire logic i_blocking_instr,
    input wire logic i_return_from_interrupt,
    output logic o_hw_call,
    output logic [15:0] o_vector,
    output logic o_call_busy,
    output logic [NFLAGS-1:0] o_flags,
    output logic [2:0] o_in_service
);
    tsic_ext_if ext_bus ();

    logic [1:0] phase_ff;
    logic mc_c4;
    logic [NFLAGS-1:0] flags_ff;
    logic [NFLAGS-1:0] nxt_flags;
    logic [NFLAGS-1:0] hw_set;
    logic [2:0] ins_ff;
    logic [2:0] nxt_ins;
    logic [2:0] mcs_ff;
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] hi_req;
    logic [NSRC-1:0] lo_req;
    logic pf_go;
    logic hi_go;
    logic lo_go;
    logic grant;
    logic [3:0] win_idx;

    function automatic logic [3:0] first_idx(input logic [NSRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : first_idx

    // Source requests, index 0 highest
    function automatic logic [NSRC-1:0] src_req(input logic [NFLAGS-1:0] f);
        return {f[F_WDOG], f[F_EXT5:F_EXT2], f[F_RI1] | f[F_TI1],
                f[F_RLD_OVF] | f[F_RLD_EXT], f[F_RI0] | f[F_TI0], f[F_OVF1],
                f[F_EXT1], f[F_OVF0], f[F_EXT0]};
    endfunction : src_req

    // Flags that vectoring clears for a given source
    function automatic logic [NFLAGS-1:0] vec_clear(input logic [3:0] s,
            input logic edge0, input logic edge1, input logic [3:0] hc);
        logic [NFLAGS-1:0] m;
        m = '0;
        if (s == S_EXT0) begin
            m[F_EXT0] = edge0;
        end else if (s == S_EXT1) begin
            m[F_EXT1] = edge1;
        end else if (s == S_OVF0) begin
            m[F_OVF0] = 1'b1;
        end else if (s == S_OVF1) begin
            m[F_OVF1] = 1'b1;
        end else if (s >= S_EXT2 && s <= S_EXT5) begin
            m[F_EXT2 + int'(s - S_EXT2)] = hc[2'(s - S_EXT2)];
        end
        return m;
    endfunction : vec_clear

    tsic_ext_sampler u_sampler (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_pins_n({i_ext_req_five_n, i_ext_req_four_n, i_ext_req_three_n,
                   i_ext_req_two_n, i_ext_req_one_n, i_ext_req_zero_n}),
        .bus(ext_bus.sampler)
    );

    // Machine-cycle phase divider
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    assign ext_bus.c3_en = (phase_ff == PH_C3);
    assign mc_c4 = (phase_ff == PH_C4);

    // Poll and resolve on current flags every machine cycle
    always_comb begin
        req = src_req(flags_ff) & i_src_enable;
        hi_req = req & i_src_priority & {NSRC{i_global_enable}};
        lo_req = req & ~i_src_priority & {NSRC{i_global_enable}};
        pf_go = i_power_fail_request & i_pf_enable & ~ins_ff[T_PF];
        hi_go = (|hi_req) & ~ins_ff[T_PF] & ~ins_ff[T_HIGH];
        lo_go = (|lo_req) & ~(|ins_ff);
        grant = mc_c4 & i_last_cycle & ~i_blocking_instr & (mcs_ff == 3'h0)
              & (pf_go | hi_go | lo_go);
        win_idx = hi_go ? first_idx(hi_req) : first_idx(lo_req);
    end

    // Hardware set events; edge flags for inputs two to five always
    always_comb begin
        hw_set = '0;
        hw_set[F_EXT0] = i_trig_type_zero & ext_bus.fall[0];
        hw_set[F_EXT1] = i_trig_type_one & ext_bus.fall[1];
        hw_set[F_EXT5:F_EXT2] = ext_bus.fall[5:2];
        hw_set[F_OVF0] = i_timer_zero_ovf;
        hw_set[F_OVF1] = i_timer_one_ovf;
        hw_set[F_RLD_OVF] = i_reload_timer_ovf;
        hw_set[F_RLD_EXT] = i_reload_timer_ext;
        hw_set[F_WDOG] = i_watchdog_timeout;
        hw_set[F_RI0] = i_serial0_rx_done;
        hw_set[F_TI0] = i_serial0_tx_done;
        hw_set[F_RI1] = i_serial1_rx_done;
        hw_set[F_TI1] = i_serial1_tx_done;
    end

    // Vector clear, then software write, then hardware set wins
    always_comb begin
        nxt_flags = flags_ff;
        if (grant && !pf_go) begin
            nxt_flags = nxt_flags & ~vec_clear(win_idx, i_trig_type_zero,
                i_trig_type_one, i_hw_clear_select);
        end
        if (i_flag_wr) begin
            nxt_flags = (nxt_flags & ~i_flag_wr_sel)
                      | (i_flag_wr_val & i_flag_wr_sel);
        end
        nxt_flags = nxt_flags | hw_set;
        // Level mode: flag follows the sampled pin
        if (!i_trig_type_zero) begin
            nxt_flags[F_EXT0] = ext_bus.low[0];
        end
        if (!i_trig_type_one) begin
            nxt_flags[F_EXT1] = ext_bus.low[1];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // In-service tiers; return-from-interrupt clears the highest
    always_comb begin
        nxt_ins = ins_ff;
        if (i_return_from_interrupt) begin
            if (ins_ff[T_PF]) begin
                nxt_ins[T_PF] = 1'b0;
            end else if (ins_ff[T_HIGH]) begin
                nxt_ins[T_HIGH] = 1'b0;
            end else begin
                nxt_ins[T_LOW] = 1'b0;
            end
        end
        if (grant) begin
            if (pf_go) begin
                nxt_ins[T_PF] = 1'b1;
            end else if (hi_go) begin
                nxt_ins[T_HIGH] = 1'b1;
            end else begin
                nxt_ins[T_LOW] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ins_ff <= INS_RST;
        end else begin
            ins_ff <= nxt_ins;
        end
    end

    // Call sequence length in machine cycles
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mcs_ff <= 3'h0;
            o_call_busy <= 1'b0;
        end else if (grant) begin
            mcs_ff <= CALL_MCS;
            o_call_busy <= 1'b1;
        end else if (mc_c4 && mcs_ff != 3'h0) begin
            mcs_ff <= mcs_ff - 3'h1;
            o_call_busy <= (mcs_ff != 3'h1);
        end
    end

    // Call strobe and vector; the core pushes only the program counter
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hw_call <= 1'b0;
            o_vector <= 16'h0000;
        end else begin
            o_hw_call <= grant;
            if (grant) begin
                o_vector <= pf_go ? PF_VECTOR : VEC[win_idx];
            end
        end
    end

    assign o_flags = flags_ff;
    assign o_in_service = ins_ff;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_busy_half;
        o_call_busy [*8];
    endsequence

    property p_call_len;
        o_hw_call |-> s_busy_half ##1 s_busy_half ##1 !o_call_busy;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call busy not 16 clocks");

    property p_call_cond;
        o_hw_call |-> $past(mc_c4) && $past(i_last_cycle) && !$past(i_blocking_instr)
            && !$past(o_call_busy);
    endproperty
    a_call_cond: assert property (p_call_cond) else $error("call outside allowed poll");

    property p_vector;
        grant && !pf_go |=> o_hw_call && o_vector == VEC[$past(win_idx)];
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_ovf0_clear;
        grant && !pf_go && win_idx == S_OVF0 && !i_timer_zero_ovf && !i_flag_wr
            |=> !flags_ff[F_OVF0];
    endproperty
    a_ovf0_clear: assert property (p_ovf0_clear) else $error("timer0 flag kept");

    property p_edge_set;
        i_trig_type_zero && ext_bus.fall[0] |=> flags_ff[F_EXT0];
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not flagged");

    property p_serial_keep;
        grant && flags_ff[F_RI0] && !i_flag_wr |=> flags_ff[F_RI0];
    endproperty
    a_serial_keep: assert property (p_serial_keep) else $error("serial flag cleared");

    property p_nest;
        grant && !pf_go && !hi_go |-> ins_ff == 3'h0;
    endproperty
    a_nest: assert property (p_nest) else $error("low pre-empts service");

    property p_global;
        grant && !i_global_enable |-> pf_go;
    endproperty
    a_global: assert property (p_global) else $error("global enable ignored");

    property p_return_from_interrupt;
        i_return_from_interrupt && ins_ff[T_HIGH] && !ins_ff[T_PF] && !grant
            |=> !ins_ff[T_HIGH] && ins_ff[T_LOW] == $past(ins_ff[T_LOW]);
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not clear service");

    property p_sw_set;
        i_flag_wr && i_flag_wr_sel[F_WDOG] && i_flag_wr_val[F_WDOG] |=> flags_ff[F_WDOG];
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software set lost");

    property p_edge_clear;
        grant && !pf_go && win_idx == S_EXT0 && i_trig_type_zero && !ext_bus.fall[0]
            && !i_flag_wr |=> !flags_ff[F_EXT0];
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept");

    property p_level_keep;
        grant && !pf_go && win_idx == S_EXT0 && !i_trig_type_zero && ext_bus.low[0]
            |=> flags_ff[F_EXT0];
    endproperty
    a_level_keep: assert property (p_level_keep) else $error("level flag cleared");

    property p_ext2_hwclear;
        grant && !pf_go && win_idx == S_EXT2 && i_hw_clear_select[0] && !ext_bus.fall[2]
            && !i_flag_wr |=> !flags_ff[F_EXT2];
    endproperty
    a_ext2_hwclear: assert property (p_ext2_hwclear) else $error("hw clear missed");

    property p_reload_keep;
        grant && flags_ff[F_RLD_OVF] && !i_flag_wr |=> flags_ff[F_RLD_OVF];
    endproperty
    a_reload_keep: assert property (p_reload_keep) else $error("reload flag cleared");

endmodule : tsic_ctrl

// ===== tsic_cpu_model.sv
// CPU-side model: instruction boundary status and return signalling
`timescale 1ns/1ps
module tsic_cpu_model (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_stall,
    input wire logic i_block,
    input wire logic i_ret_req,
    input wire logic i_ret_kind,
    output logic o_last_cycle,
    output logic o_blocking_instr,
    output logic o_return_from_interrupt
);
    logic return_from_interrupt_ff;
    // Slow mode keeps the core inside a long instruction
    assign o_last_cycle = !i_stall;
    assign o_blocking_instr = i_block;
    assign o_return_from_interrupt = return_from_interrupt_ff;
    // A plain return pops the stack without telling the controller
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            return_from_interrupt_ff <= 1'b0;
        end else begin
            return_from_interrupt_ff <= i_ret_req & i_ret_kind;
        end
    end
endmodule : tsic_cpu_model

// ===== tsic_ctrl_tb.sv
// Self-checking bench for the interrupt controller with its CPU-side model
`timescale 1ns/1ps
module tsic_ctrl_tb import tsic_pkg::*; ;
    localparam logic [15:0] PFV = 16'h0077;
    localparam logic [15:0] VT [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
        16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
    localparam logic [14:0] FM [12] = '{15'h0001, 15'h0040, 15'h0002, 15'h0080, 15'h1800,
        15'h0300, 15'h6000, 15'h0004, 15'h0008, 15'h0010, 15'h0020, 15'h0400};
    // Sources cleared by the call itself, with hardware clear on inputs two and four
    localparam logic [11:0] HWC = 12'h28F;
    logic clk = 1'b0, rst = 1'b1, trig0 = 1'b1, fwr_en = 1'b0, gen = 1'b0, pfreq = 1'b0;
    logic stall = 1'b0, blk = 1'b0, rreq = 1'b0, rkind = 1'b0, last, blkin, return_from_interrupt, call, busy;
    logic [5:0] pin_n = 6'h3F;
    logic [8:0] hw_set = 9'h000;
    logic [14:0] fsel = 15'h0000, fval = 15'h0000, flags, exp_f;
    logic [11:0] en = 12'h000, pri = 12'h000;
    logic [15:0] vec;
    logic [2:0] ins;
    int fail_count = 0, n_compared = 0;

    always #4 clk = ~clk;

    tsic_ctrl #(.PF_VECTOR(PFV)) tsic_ctrl_i (.i_sys_clk(clk), .i_sys_rst(rst),
        .i_ext_req_zero_n(pin_n[0]), .i_ext_req_one_n(pin_n[1]), .i_ext_req_two_n(pin_n[2]),
        .i_ext_req_three_n(pin_n[3]), .i_ext_req_four_n(pin_n[4]),
        .i_ext_req_five_n(pin_n[5]), .i_trig_type_zero(trig0), .i_trig_type_one(trig0),
        .i_hw_clear_select(4'h5), .i_timer_zero_ovf(hw_set[0]), .i_timer_one_ovf(hw_set[1]),
        .i_reload_timer_ovf(hw_set[2]), .i_reload_timer_ext(hw_set[3]),
        .i_watchdog_timeout(hw_set[4]), .i_serial0_rx_done(hw_set[5]),
        .i_serial0_tx_done(hw_set[6]), .i_serial1_rx_done(hw_set[7]),
        .i_serial1_tx_done(hw_set[8]), .i_flag_wr(fwr_en), .i_flag_wr_sel(fsel),
        .i_flag_wr_val(fval), .i_src_enable(en), .i_src_priority(pri), .i_global_enable(gen),
        .i_power_fail_request(pfreq), .i_pf_enable(1'b1), .i_last_cycle(last),
        .i_blocking_instr(blkin), .i_return_from_interrupt(return_from_interrupt), .o_hw_call(call), .o_vector(vec),
        .o_call_busy(busy), .o_flags(flags), .o_in_service(ins));

    tsic_cpu_model tsic_cpu_model_i (.i_sys_clk(clk), .i_sys_rst(rst), .i_stall(stall),
        .i_block(blk), .i_ret_req(rreq), .i_ret_kind(rkind), .o_last_cycle(last),
        .o_blocking_instr(blkin), .o_return_from_interrupt(return_from_interrupt));

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Waits for one call, then measures how long the call sequence stays busy
    task automatic wait_call(input logic [15:0] v);
        int n;
        n = 0;
        while (call !== 1'b1) begin
            tick(1);
            n++;
            if (n > 100) begin
                fail_count++;
                $display("BAD call expected 1 seen %b", call);
                print_verdict();
            end
        end
        chk("vector", v, vec);
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("busy clocks", 16'h0010, 16'(n));
        if (n >= 40) begin
            print_verdict();
        end
    endtask : wait_call

    task automatic no_call;
        repeat (24) begin
            tick(1);
            chk("no call", 16'h0000, 16'(call));
        end
    endtask : no_call

    task automatic fwr(input logic [14:0] s, input logic [14:0] v);
        @(posedge clk);
        fsel <= s;
        fval <= v;
        fwr_en <= 1'b1;
        @(posedge clk);
        fwr_en <= 1'b0;
        #1;
    endtask : fwr

    task automatic hwp(input logic [8:0] m);
        @(posedge clk);
        hw_set <= m;
        @(posedge clk);
        hw_set <= 9'h000;
        #1;
    endtask : hwp

    task automatic ret(input logic k);
        @(posedge clk);
        rreq <= 1'b1;
        rkind <= k;
        @(posedge clk);
        rreq <= 1'b0;
        #1;
    endtask : ret

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("flags", 16'h0000, 16'(flags));
        chk("in service", 16'h0000, 16'(ins));
        fwr(15'h003F, 15'h003F);
        hwp(9'h1FF);
        chk("flags", 16'h7FFF, 16'(flags));
        exp_f = 15'h7FFF;
        no_call();
        @(posedge clk);
        en <= 12'hFFF;
        no_call();
        @(posedge clk);
        gen <= 1'b1;
        // Every source in turn, tie order and flag clearing per source
        for (int i = 0; i < 12; i++) begin
            wait_call(VT[i]);
            exp_f = exp_f & ~(HWC[i] ? FM[i] : 15'h0000);
            chk("flags", 16'(exp_f), 16'(flags));
            chk("in service", 16'h0001, 16'(ins));
            fwr(FM[i], 15'h0000);
            exp_f = exp_f & ~FM[i];
            ret(1'b1);
        end
        // Nesting: timers zero and one in the high tier
        @(posedge clk);
        pri <= 12'h00A;
        fwr(15'h6000, 15'h6000);
        wait_call(16'h003B);
        hwp(9'h020);
        no_call();
        hwp(9'h001);
        wait_call(16'h000B);
        chk("in service", 16'h0003, 16'(ins));
        hwp(9'h002);
        no_call();
        ret(1'b1);
        wait_call(16'h001B);
        ret(1'b0);
        no_call();
        chk("in service", 16'h0003, 16'(ins));
        ret(1'b1);
        no_call();
        chk("in service", 16'h0001, 16'(ins));
        ret(1'b1);
        wait_call(16'h0023);
        fwr(15'h7FFF, 15'h0000);
        ret(1'b1);
        // Denied requests are forgotten; blocking instructions defer the call
        @(posedge clk);
        stall <= 1'b1;
        fwr(15'h0400, 15'h0400);
        no_call();
        fwr(15'h0400, 15'h0000);
        @(posedge clk);
        stall <= 1'b0;
        no_call();
        @(posedge clk);
        blk <= 1'b1;
        fwr(15'h0400, 15'h0400);
        no_call();
        @(posedge clk);
        blk <= 1'b0;
        wait_call(16'h0063);
        fwr(15'h0400, 15'h0000);
        ret(1'b1);
        // Power-fail passes with the global enable off
        @(posedge clk);
        gen <= 1'b0;
        pfreq <= 1'b1;
        wait_call(PFV);
        chk("in service", 16'h0004, 16'(ins));
        @(posedge clk);
        pfreq <= 1'b0;
        ret(1'b1);
        tick(2);
        chk("in service", 16'h0000, 16'(ins));
        @(posedge clk);
        gen <= 1'b1;
        // External zero: edge mode, then level mode
        @(posedge clk);
        pin_n[0] <= 1'b0;
        wait_call(16'h0003);
        chk("flags", 16'h0000, 16'(flags));
        @(posedge clk);
        pin_n[0] <= 1'b1;
        ret(1'b1);
        @(posedge clk);
        trig0 <= 1'b0;
        pin_n[1:0] <= 2'b00;
        wait_call(16'h0003);
        chk("flags", 16'h0003, 16'(flags));
        ret(1'b1);
        wait_call(16'h0003);
        @(posedge clk);
        pin_n[1:0] <= 2'b11;
        tick(12);
        chk("flags", 16'h0000, 16'(flags));
        ret(1'b1);
        no_call();
        // Reset in the middle of a call sequence
        fwr(15'h7FFF, 15'h7FFF);
        tick(12);
        chk("busy", 16'h0001, 16'(busy));
        @(posedge clk);
        rst <= 1'b1;
        tick(2);
        @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("flags", 16'h0000, 16'(flags));
        chk("in service", 16'h0000, 16'(ins));
        chk("busy", 16'h0000, 16'(busy));
        chk("vector", 16'h0000, vec);
        print_verdict();
    end
endmodule : tsic_ctrl_tb
